/* File: hw/arfwc_params.svh */
// named offsets, field positions and reset values of the result format and window block
`ifndef ARFWC_PARAMS_SVH
`define ARFWC_PARAMS_SVH

`define ARFWC_CODE_W         10
`define ARFWC_WORD_W         16
`define ARFWC_BYTE_W         8

`define ARFWC_ADDR_RESULT_LO 8'hbd
`define ARFWC_ADDR_RESULT_HI 8'hbe
`define ARFWC_ADDR_UPPER_LO  8'hc3
`define ARFWC_ADDR_UPPER_HI  8'hc4
`define ARFWC_ADDR_LOWER_LO  8'hc5
`define ARFWC_ADDR_LOWER_HI  8'hc6
`define ARFWC_ADDR_CTRL      8'he8

`define ARFWC_CTRL_LJ_BIT    0
`define ARFWC_CTRL_DIFF_BIT  1
`define ARFWC_CTRL_FLAG_BIT  3

`define ARFWC_UPPER_RST      8'hff
`define ARFWC_LOWER_RST      8'h00
`define ARFWC_RESULT_RST     16'h0000
`define ARFWC_RDATA_RST      8'h00
`define ARFWC_UNMAPPED_RD    8'h00

`endif

/* File: hw/arfwc_pkg.sv */
// types shared by the result format and window compare block
`include "arfwc_params.svh"

package arfwc_pkg;

  typedef struct packed {
    logic                      done;
    logic [`ARFWC_CODE_W-1:0]  code;
  } arfwc_conv_t;

  typedef struct packed {
    logic                      wrEn;
    logic                      rdEn;
    logic [`ARFWC_BYTE_W-1:0]  addr;
    logic [`ARFWC_BYTE_W-1:0]  wrData;
  } arfwc_sfr_t;

endpackage : arfwc_pkg

/* File: hw/arfwc_format.sv */
// placement of a raw conversion code into the 16-bit result word
`timescale 1ns/100ps
`include "arfwc_params.svh"

module arfwc_format #(
  parameter int CODE_W = `ARFWC_CODE_W
) (
  input  logic [CODE_W-1:0]        code,
  input  logic                     leftJustify,
  input  logic                     differential,
  output logic [`ARFWC_WORD_W-1:0] word
);

  localparam int PAD_W = `ARFWC_WORD_W - CODE_W;

  always_comb begin
    if (leftJustify) begin
      word = {code, {PAD_W{1'b0}}};
    end else if (differential) begin
      word = {{PAD_W{code[CODE_W-1]}}, code};
    end else begin
      word = {{PAD_W{1'b0}}, code};
    end
  end

endmodule : arfwc_format

/* File: hw/arfwc_top.sv */
// result formatting and window comparison with its special function registers
`timescale 1ns/100ps
`include "arfwc_params.svh"

module arfwc_top #(
  parameter int CODE_W = `ARFWC_CODE_W
) (
  input  logic                     ref_clk,
  input  logic                     resetn,
  input  arfwc_pkg::arfwc_sfr_t    sfrReq,
  input  arfwc_pkg::arfwc_conv_t   conv,
  output logic [`ARFWC_BYTE_W-1:0] sfrRdData,
  output logic                     sfrRdValid,
  output logic                     windowFlag
);
  import arfwc_pkg::*;

  logic [`ARFWC_BYTE_W-1:0] upperHighReg;
  logic [`ARFWC_BYTE_W-1:0] upperLowReg;
  logic [`ARFWC_BYTE_W-1:0] lowerHighReg;
  logic [`ARFWC_BYTE_W-1:0] lowerLowReg;
  logic                     leftJustifyReg;
  logic                     diffModeReg;
  logic                     windowFlagReg;
  logic [`ARFWC_WORD_W-1:0] resultReg;
  logic                     resultFreshReg;
  logic [`ARFWC_BYTE_W-1:0] sfrRdDataReg;
  logic [`ARFWC_BYTE_W-1:0] sfrRdData_next;
  logic                     sfrRdValidReg;
  logic [`ARFWC_WORD_W-1:0] fmtWord;
  logic [`ARFWC_WORD_W-1:0] upperWord;
  logic [`ARFWC_WORD_W-1:0] lowerWord;
  logic                     aboveUpper;
  logic                     belowLower;
  logic                     limitsInverted;
  logic                     windowHit;
  logic [`ARFWC_BYTE_W-1:0] ctrlView;

  function automatic logic wrHit(arfwc_sfr_t r, logic [`ARFWC_BYTE_W-1:0] a);
    return r.wrEn && (r.addr == a);
  endfunction : wrHit

  function automatic logic wordGreater(logic [`ARFWC_WORD_W-1:0] a,
                                       logic [`ARFWC_WORD_W-1:0] b,
                                       logic                     signedCmp);
    if (signedCmp) begin
      return $signed(a) > $signed(b);
    end
    return a > b;
  endfunction : wordGreater

  // code placement
  arfwc_format #(
    .CODE_W       (CODE_W)
  ) u_format (
    .code         (conv.code[CODE_W-1:0]),
    .leftJustify  (leftJustifyReg),
    .differential (diffModeReg),
    .word         (fmtWord)
  );

  // result capture
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      resultReg      <= `ARFWC_RESULT_RST;
      resultFreshReg <= 1'b0;
    end else begin
      resultFreshReg <= conv.done;
      if (conv.done) begin
        resultReg <= fmtWord;
      end
    end
  end

  // control bits
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      leftJustifyReg <= 1'b0;
      diffModeReg    <= 1'b0;
    end else if (wrHit(sfrReq, `ARFWC_ADDR_CTRL)) begin
      leftJustifyReg <= sfrReq.wrData[`ARFWC_CTRL_LJ_BIT];
      diffModeReg    <= sfrReq.wrData[`ARFWC_CTRL_DIFF_BIT];
    end
  end

  // limit registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      upperHighReg <= `ARFWC_UPPER_RST;
      upperLowReg  <= `ARFWC_UPPER_RST;
      lowerHighReg <= `ARFWC_LOWER_RST;
      lowerLowReg  <= `ARFWC_LOWER_RST;
    end else begin
      if (wrHit(sfrReq, `ARFWC_ADDR_UPPER_HI)) begin
        upperHighReg <= sfrReq.wrData;
      end
      if (wrHit(sfrReq, `ARFWC_ADDR_UPPER_LO)) begin
        upperLowReg <= sfrReq.wrData;
      end
      if (wrHit(sfrReq, `ARFWC_ADDR_LOWER_HI)) begin
        lowerHighReg <= sfrReq.wrData;
      end
      if (wrHit(sfrReq, `ARFWC_ADDR_LOWER_LO)) begin
        lowerLowReg <= sfrReq.wrData;
      end
    end
  end

  // window comparison on current result contents
  always_comb begin
    upperWord      = {upperHighReg, upperLowReg};
    lowerWord      = {lowerHighReg, lowerLowReg};
    aboveUpper     = wordGreater(resultReg, upperWord, diffModeReg);
    belowLower     = wordGreater(lowerWord, resultReg, diffModeReg);
    limitsInverted = wordGreater(lowerWord, upperWord, diffModeReg);
    if (limitsInverted) begin
      windowHit = aboveUpper && belowLower;
    end else begin
      windowHit = aboveUpper || belowLower;
    end
  end

  // sticky compare flag, set beats clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      windowFlagReg <= 1'b0;
    end else if (resultFreshReg && windowHit) begin
      windowFlagReg <= 1'b1;
    end else if (wrHit(sfrReq, `ARFWC_ADDR_CTRL) && !sfrReq.wrData[`ARFWC_CTRL_FLAG_BIT]) begin
      windowFlagReg <= 1'b0;
    end
  end

  // read mux
  always_comb begin
    ctrlView                        = '0;
    ctrlView[`ARFWC_CTRL_LJ_BIT]   = leftJustifyReg;
    ctrlView[`ARFWC_CTRL_DIFF_BIT] = diffModeReg;
    ctrlView[`ARFWC_CTRL_FLAG_BIT] = windowFlagReg;
    case (sfrReq.addr)
      `ARFWC_ADDR_RESULT_HI: sfrRdData_next = resultReg[`ARFWC_WORD_W-1:`ARFWC_BYTE_W];
      `ARFWC_ADDR_RESULT_LO: sfrRdData_next = resultReg[`ARFWC_BYTE_W-1:0];
      `ARFWC_ADDR_UPPER_HI:  sfrRdData_next = upperHighReg;
      `ARFWC_ADDR_UPPER_LO:  sfrRdData_next = upperLowReg;
      `ARFWC_ADDR_LOWER_HI:  sfrRdData_next = lowerHighReg;
      `ARFWC_ADDR_LOWER_LO:  sfrRdData_next = lowerLowReg;
      `ARFWC_ADDR_CTRL:      sfrRdData_next = ctrlView;
      default:               sfrRdData_next = `ARFWC_UNMAPPED_RD;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sfrRdDataReg  <= `ARFWC_RDATA_RST;
      sfrRdValidReg <= 1'b0;
    end else begin
      sfrRdValidReg <= sfrReq.rdEn;
      if (sfrReq.rdEn) begin
        sfrRdDataReg <= sfrRdData_next;
      end
    end
  end

  assign sfrRdData  = sfrRdDataReg;
  assign sfrRdValid = sfrRdValidReg;
  assign windowFlag = windowFlagReg;

  // checks
  chk_result_load: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    conv.done |=> resultFreshReg && (resultReg == $past(fmtWord)))
    else $error("result not loaded after conversion");

  chk_single_right: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    conv.done && !diffModeReg && !leftJustifyReg
    |=> resultReg == {6'h00, $past(conv.code)})
    else $error("single-ended right result wrong");

  chk_left_place: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    conv.done && leftJustifyReg |=> resultReg == {$past(conv.code), 6'h00})
    else $error("left-justified result wrong");

  chk_full_scale: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    conv.done && !diffModeReg && (conv.code == 10'h3ff)
    |=> resultReg == ($past(leftJustifyReg) ? 16'hffc0 : 16'h03ff))
    else $error("full-scale code misplaced");

  chk_sign_extend: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    conv.done && diffModeReg && !leftJustifyReg
    |=> (resultReg[15:10] == {6{$past(conv.code[9])}}) && (resultReg[9:0] == $past(conv.code)))
    else $error("differential sign extension wrong");

  chk_flag_set: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    conv.done ##1 windowHit |=> windowFlag)
    else $error("window flag not set on hit");

  chk_flag_sticky: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    windowFlag && !(wrHit(sfrReq, `ARFWC_ADDR_CTRL) && !sfrReq.wrData[`ARFWC_CTRL_FLAG_BIT])
    |=> windowFlag)
    else $error("window flag dropped without clear");

  chk_flag_cause: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    $rose(windowFlag) |-> $past(resultFreshReg) && $past(windowHit))
    else $error("window flag set without hit");

  chk_signed_hit: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    diffModeReg && resultReg[15] && !lowerWord[15] && !limitsInverted |-> windowHit)
    else $error("signed compare ignored sign");

  chk_upper_write: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    wrHit(sfrReq, `ARFWC_ADDR_UPPER_HI) ##1 sfrReq.rdEn && (sfrReq.addr == `ARFWC_ADDR_UPPER_HI)
    |=> sfrRdValid && (sfrRdData == $past(sfrReq.wrData, 2)))
    else $error("upper high byte readback wrong");

  chk_lower_write: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    wrHit(sfrReq, `ARFWC_ADDR_LOWER_LO) |=> lowerLowReg == $past(sfrReq.wrData))
    else $error("lower low byte not written");

endmodule : arfwc_top

/* File: sim/arfwc_conv_model.sv */
// conversion core model delivering one-cycle result pulses
`timescale 1ns/100ps
`include "arfwc_params.svh"
module arfwc_conv_model (
  input  logic                   ref_clk,
  output arfwc_pkg::arfwc_conv_t conv
);
  import arfwc_pkg::*;
  initial conv = '0;
  // one done pulse per code, code scrambled outside the pulse
  task automatic send(input logic [`ARFWC_CODE_W-1:0] code);
    @(posedge ref_clk);
    #1;
    conv.code = code;
    conv.done = 1'b1;
    @(posedge ref_clk);
    #1;
    conv.done = 1'b0;
    conv.code = ~code;
  endtask : send
endmodule : arfwc_conv_model

/* File: sim/adc_result_format_window_compare_tb.sv */
// self-checking bench of the result format and window compare block
`timescale 1ns/100ps
`include "arfwc_params.svh"
module adc_result_format_window_compare_tb;
  import arfwc_pkg::*;
  logic        ref_clk;
  logic        resetn;
  arfwc_sfr_t  sfrReq;
  arfwc_conv_t conv;
  logic [7:0]  sfrRdData;
  logic        sfrRdValid;
  logic        windowFlag;
  int          fail_count;
  int          cmp_count;
  // mode, code, expected word
  logic [27:0] fmt [8] = '{{2'h0, 10'h3ff, 16'h03ff}, {2'h0, 10'h200, 16'h0200},
    {2'h1, 10'h3ff, 16'hffc0}, {2'h1, 10'h200, 16'h8000}, {2'h2, 10'h1ff, 16'h01ff},
    {2'h2, 10'h200, 16'hfe00}, {2'h3, 10'h1ff, 16'h7fc0}, {2'h3, 10'h200, 16'h8000}};
  // mode, upper, lower, code, flag
  logic [44:0] win [8] = '{{2'h0, 16'h0100, 16'h0010, 10'h101, 1'b1},
    {2'h0, 16'h0100, 16'h0010, 10'h100, 1'b0}, {2'h0, 16'h0100, 16'h0010, 10'h00f, 1'b1},
    {2'h0, 16'h0010, 16'h0100, 10'h080, 1'b1}, {2'h0, 16'h0010, 16'h0100, 10'h100, 1'b0},
    {2'h2, 16'h0010, 16'hfff0, 10'h3e0, 1'b1}, {2'h2, 16'h0010, 16'hfff0, 10'h3f8, 1'b0},
    {2'h1, 16'h8000, 16'h4000, 10'h3ff, 1'b1}};

  arfwc_top DUT (.ref_clk(ref_clk), .resetn(resetn), .sfrReq(sfrReq), .conv(conv),
    .sfrRdData(sfrRdData), .sfrRdValid(sfrRdValid), .windowFlag(windowFlag));
  arfwc_conv_model core (.ref_clk(ref_clk), .conv(conv));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    sfrReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge ref_clk);
    #1;
    sfrReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    #1;
    sfrReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(posedge ref_clk);
    #1;
    sfrReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: 8'hff};
    chk({7'h00, sfrRdValid, sfrRdData}, {8'h01, exp});
  endtask : rd

  task automatic t_reset;
    chk({15'h0000, windowFlag}, 16'h0000);
    rd(8'hc4, 8'hff);
    rd(8'hc3, 8'hff);
    rd(8'hc6, 8'h00);
    rd(8'he8, 8'h00);
    rd(8'h10, 8'h00);
  endtask : t_reset

  task automatic t_regs;
    wr(8'hc4, 8'h5a);
    wr(8'hc3, 8'ha5);
    wr(8'h10, 8'h33);
    wr(8'hbd, 8'h77);
    rd(8'hc4, 8'h5a);
    rd(8'hc3, 8'ha5);
    rd(8'h10, 8'h00);
    rd(8'hbd, 8'h00);
  endtask : t_regs

  task automatic t_format;
    for (int i = 0; i < 8; i++) begin
      wr(8'he8, {6'h00, fmt[i][27:26]});
      core.send(fmt[i][25:16]);
      rd(8'hbe, fmt[i][15:8]);
      rd(8'hbd, fmt[i][7:0]);
    end
  endtask : t_format

  task automatic t_window;
    for (int i = 0; i < 8; i++) begin
      wr(8'he8, {6'h00, win[i][44:43]});
      wr(8'hc4, win[i][42:35]);
      wr(8'hc3, win[i][34:27]);
      wr(8'hc6, win[i][26:19]);
      wr(8'hc5, win[i][18:11]);
      core.send(win[i][10:1]);
      @(posedge ref_clk);
      #1;
      chk({15'h0000, windowFlag}, {15'h0000, win[i][0]});
      rd(8'he8, {4'h0, win[i][0], 1'b0, win[i][44:43]});
      wr(8'he8, {6'h00, win[i][44:43]});
      chk({15'h0000, windowFlag}, 16'h0000);
    end
  endtask : t_window

  // write then read of the same byte on adjacent edges
  task automatic t_b2b;
    @(posedge ref_clk);
    #1;
    sfrReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: 8'hc4, wrData: 8'h3c};
    @(posedge ref_clk);
    #1;
    sfrReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: 8'hc4, wrData: 8'h00};
    @(posedge ref_clk);
    #1;
    sfrReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: 8'h00, wrData: 8'h00};
    chk({7'h00, sfrRdValid, sfrRdData}, 16'h013c);
  endtask : t_b2b

  // reset in mid-run clears the flag and restores the upper limit bytes
  task automatic t_midreset;
    @(posedge ref_clk);
    #1;
    resetn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    chk({15'h0000, windowFlag}, 16'h0000);
    rd(8'hc4, 8'hff);
    rd(8'hc3, 8'hff);
  endtask : t_midreset

  initial begin
    #100000;
    fail_count++;
    end_sim();
  end

  initial begin
    resetn = 1'b0;
    sfrReq = '0;
    fail_count = 0;
    cmp_count = 0;
    repeat (10) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_regs();
    t_format();
    t_window();
    t_b2b();
    t_midreset();
    end_sim();
  end
endmodule : adc_result_format_window_compare_tb
